// ### hw/bst_pkg.sv
package bst_pkg;

	localparam int IR_W    = 5;
	localparam int N_IN    = 4;
	localparam int N_OUT   = 2;
	localparam int N_BIDIR = 8;
	localparam int BSR_LEN = N_IN + N_OUT + N_BIDIR + 1;

	// Boundary cell positions, cell 0 sits next to the serial output
	localparam int BSR_IN_LSB    = 0;
	localparam int BSR_OUT_LSB   = 4;
	localparam int BSR_BIDIR_LSB = 6;
	localparam int BSR_CTL       = 14;

	localparam logic [4:0] OP_EXTEST               = 5'h00;
	localparam logic [4:0] OP_SAMPLE               = 5'h01;
	localparam logic [4:0] INTERNAL_SCAN_ENABLE_OP = 5'h02;
	localparam logic [4:0] OP_CLAMP                = 5'h04;
	localparam logic [4:0] OP_BYPASS               = 5'h1F;
	// No identification register exists, so this code falls to bypass
	localparam logic [4:0] OP_IDCODE               = 5'h1E;
	localparam logic [4:0] IR_CAPTURE              = 5'h0D;

	localparam logic [14:0] BSR_RESET = 15'h0000;

	typedef enum logic [15:0] {
		ST_TLR    = 16'h0001,
		ST_RTI    = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR  = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PA_DR  = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UP_DR  = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR  = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PA_IR  = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UP_IR  = 16'h8000
	} bst_state_t;

	typedef struct packed {
		logic               ctl;
		logic [N_BIDIR-1:0] bidir;
		logic [N_OUT-1:0]   outp;
		logic [N_IN-1:0]    inp;
	} bst_cells_t;

	typedef struct packed {
		logic sel_bsr;
		logic drive_pins;
		logic scan_en;
	} bst_mode_t;

	localparam bst_mode_t MODE_RESET = 3'h0;

endpackage

// ### hw/bst_sync.sv
`timescale 1ns/10ps
`default_nettype none

module bst_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb
	begin
		next_meta = rst ? '0 : d;
		next_q    = rst ? '0 : meta;
	end

	always_ff @(posedge clk)
	begin
		meta <= next_meta;
		q    <= next_q;
	end

endmodule

`default_nettype wire

// ### hw/bst_tap.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE1: Sixteen-state TAP machine clocked by TCK, TMS
// RULE2: Power-on reset forces test-logic-reset state
// RULE3: Tester keeps port idle during bus cycles
// RULE4: Every system pin has a boundary cell
// RULE5: Five-bit instruction register, shift and latched stage
// RULE6: Instruction register shifts TDI each rising edge
// RULE7: TDI feeds IR MSB, LSB drives TDO
// RULE8: New instruction acts only when latched
// RULE9: Instruction capture loads 1101, shifted out LSB-first
// RULE10: Test reset asynchronously latches identification instruction
// RULE11: New instruction becomes active on falling edge
// RULE12: EXTEST scans boundary register, drives pins at falling
// RULE13: EXTEST captures system inputs on rising edges
// RULE14: SAMPLE snapshots pins, outputs capture driven values
// RULE15: SAMPLE moves shift cells to update cells
// RULE16: Opcode 00010 enables internal scan mode
// RULE17: CLAMP holds pins from boundary, bypass path
// RULE18: BYPASS opcode selects one-bit bypass register
// RULE19: BYPASS leaves all pins in system function
// RULE20: Selected data register shifts toward TDO uninverted
// RULE21: Five TMS-high clocks reset the TAP
// RULE22: Control cell one selects pins as outputs
// RULE23: Phases follow the standard TAP state diagram
// RULE24: Unlisted opcodes select bypass, pins stay normal
module bst_tap (
	input  wire logic                        sys_clk,
	input  wire logic                        srst,
	input  wire logic                        tck,
	input  wire logic                        trst_n,
	input  wire logic                        tms,
	input  wire logic                        tdi,
	output var  logic                        tdo,
	output var  logic                        tdo_oe,
	input  wire logic [bst_pkg::N_OUT-1:0]   core_out,
	input  wire logic [bst_pkg::N_BIDIR-1:0] core_bidir_out,
	input  wire logic                        core_bidir_oe,
	output var  logic [bst_pkg::N_IN-1:0]    core_in,
	output var  logic [bst_pkg::N_BIDIR-1:0] core_bidir_in,
	input  wire logic [bst_pkg::N_IN-1:0]    pad_in,
	output var  logic [bst_pkg::N_OUT-1:0]   pad_out,
	output var  logic [bst_pkg::N_BIDIR-1:0] pad_bidir_out,
	output var  logic                        pad_bidir_oe,
	input  wire logic [bst_pkg::N_BIDIR-1:0] pad_bidir_in,
	output var  logic                        scan_en,
	output var  logic                        pins_held
);

	function automatic bst_pkg::bst_mode_t bst_decode(
		input logic [bst_pkg::IR_W-1:0] op
	);
		bst_pkg::bst_mode_t m;
		m = bst_pkg::MODE_RESET;
		unique case (op)
			bst_pkg::OP_EXTEST:
			begin
				m.sel_bsr    = 1'b1; // see RULE12
				m.drive_pins = 1'b1;
			end
			bst_pkg::OP_SAMPLE:
				m.sel_bsr = 1'b1; // see RULE14
			bst_pkg::INTERNAL_SCAN_ENABLE_OP:
				m.scan_en = 1'b1; // see RULE16
			bst_pkg::OP_CLAMP:
				m.drive_pins = 1'b1; // see RULE17
			// BYPASS and every unlisted code: bypass path, pins normal
			default:
				m = bst_pkg::MODE_RESET; // see RULE18 see RULE19 see RULE24
		endcase
		return m;
	endfunction

	bst_pkg::bst_state_t state;
	logic                por_tck;
	bst_pkg::bst_cells_t cap_raw;
	bst_pkg::bst_cells_t cap_sync;

	logic [bst_pkg::IR_W-1:0] ir_shift;
	logic [bst_pkg::IR_W-1:0] next_ir_shift;
	logic [bst_pkg::IR_W-1:0] ir_active;
	logic [bst_pkg::IR_W-1:0] next_ir_active;
	bst_pkg::bst_mode_t       mode;
	bst_pkg::bst_mode_t       next_mode;

	bst_pkg::bst_cells_t bsr;
	bst_pkg::bst_cells_t next_bsr;
	bst_pkg::bst_cells_t bsr_upd;
	bst_pkg::bst_cells_t next_bsr_upd;
	logic                bypass;
	logic                next_bypass;
	logic                next_tdo;
	logic                next_tdo_oe;

	// Power-on reset arrives on sys_clk; TCK may be idle until the tester
	// starts, so the machine is held in reset once TCK begins to toggle.
	bst_sync #(
		.W (1)
	) u_por_sync (
		.clk (tck),
		.rst (1'b0),
		.d   (srst),
		.q   (por_tck)
	);

	bst_tap_fsm u_fsm (
		.tck    (tck),
		.trst_n (trst_n),
		.por    (por_tck),
		.tms    (tms),
		.state  (state)
	);

	// Pin levels and driven values come from the system domain
	always_comb
	begin
		cap_raw       = bst_pkg::BSR_RESET;
		cap_raw.inp   = pad_in;         // see RULE13
		cap_raw.outp  = pad_out;        // see RULE14
		cap_raw.bidir = pad_bidir_in;
		cap_raw.ctl   = pad_bidir_oe;
	end

	bst_sync #(
		.W (bst_pkg::BSR_LEN)
	) u_cap_sync (
		.clk (tck),
		.rst (1'b0),
		.d   (cap_raw),
		.q   (cap_sync)
	);

	// Instruction register, shift stage on rising TCK
	always_comb
	begin
		next_ir_shift = ir_shift;
		if (state == bst_pkg::ST_CAP_IR)
			next_ir_shift = bst_pkg::IR_CAPTURE; // see RULE9
		else if (state == bst_pkg::ST_SH_IR)
			next_ir_shift = {tdi, ir_shift[bst_pkg::IR_W-1:1]}; // see RULE6 see RULE7
	end

	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			ir_shift <= bst_pkg::IR_CAPTURE;
		else
			ir_shift <= next_ir_shift; // see RULE5
	end

	// Latched stage on falling TCK; the decoded mode is kept in flops so
	// the system-side synchroniser never sees a decoder glitch.
	always_comb
	begin
		next_ir_active = ir_active;
		if (state == bst_pkg::ST_TLR)
			next_ir_active = bst_pkg::OP_IDCODE;
		else if (state == bst_pkg::ST_UP_IR)
			next_ir_active = ir_shift; // see RULE8 see RULE11
		next_mode = bst_decode(next_ir_active);
	end

	always_ff @(negedge tck or negedge trst_n)
	begin
		if (!trst_n)
		begin
			ir_active <= bst_pkg::OP_IDCODE; // see RULE10
			mode      <= bst_pkg::MODE_RESET;
		end
		else
		begin
			ir_active <= next_ir_active;
			mode      <= next_mode;
		end
	end

	// Data registers, capture and shift on rising TCK
	always_comb
	begin
		next_bypass = bypass;
		next_bsr    = bsr;
		if (state == bst_pkg::ST_CAP_DR)
		begin
			next_bypass = 1'b0;
			if (mode.sel_bsr)
				next_bsr = cap_sync; // see RULE13 see RULE14
		end
		else if (state == bst_pkg::ST_SH_DR)
		begin
			next_bypass = tdi; // see RULE18
			if (mode.sel_bsr)
				next_bsr = {tdi, bsr[bst_pkg::BSR_LEN-1:1]}; // see RULE20
		end
	end

	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
		begin
			bypass <= 1'b0;
			bsr    <= bst_pkg::BSR_RESET;
		end
		else
		begin
			bypass <= next_bypass;
			bsr    <= next_bsr;
		end
	end

	// Update cells load on falling TCK and hold through CLAMP
	always_comb
	begin
		next_bsr_upd = bsr_upd;
		if (state == bst_pkg::ST_UP_DR && mode.sel_bsr)
			next_bsr_upd = bsr; // see RULE15 see RULE12
	end

	always_ff @(negedge tck or negedge trst_n)
	begin
		if (!trst_n)
			bsr_upd <= bst_pkg::BSR_RESET;
		else
			bsr_upd <= next_bsr_upd;
	end

	// Serial output changes on falling TCK, driven only while shifting
	always_comb
	begin
		next_tdo    = tdo;
		next_tdo_oe = 1'b0;
		if (state == bst_pkg::ST_SH_IR)
		begin
			next_tdo    = ir_shift[0]; // see RULE7 see RULE9
			next_tdo_oe = 1'b1;
		end
		else if (state == bst_pkg::ST_SH_DR)
		begin
			next_tdo    = mode.sel_bsr ? bsr[0] : bypass; // see RULE17 see RULE20
			next_tdo_oe = 1'b1;
		end
	end

	always_ff @(negedge tck or negedge trst_n)
	begin
		if (!trst_n)
		begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end
		else
		begin
			tdo    <= next_tdo;
			tdo_oe <= next_tdo_oe;
		end
	end

	// Pin multiplexers; inputs always reach the core unchanged
	always_comb
	begin
		core_in       = pad_in;
		core_bidir_in = pad_bidir_in;
		if (mode.drive_pins)
		begin
			pad_out       = bsr_upd.outp;  // see RULE4 see RULE12 see RULE17
			pad_bidir_out = bsr_upd.bidir;
			pad_bidir_oe  = bsr_upd.ctl;   // see RULE22
		end
		else
		begin
			pad_out       = core_out;      // see RULE19
			pad_bidir_out = core_bidir_out;
			pad_bidir_oe  = core_bidir_oe;
		end
	end

	// Mode levels handed to the system clock domain
	bst_sync #(
		.W (2)
	) u_mode_sync (
		.clk (sys_clk),
		.rst (srst),
		.d   ({mode.scan_en, mode.drive_pins}),
		.q   ({scan_en, pins_held})
	);

endmodule

`default_nettype wire

// ### hw/bst_tap_fsm.sv
`timescale 1ns/10ps
`default_nettype none

module bst_tap_fsm (
	input  wire logic              tck,
	input  wire logic              trst_n,
	input  wire logic              por,
	input  wire logic              tms,
	output var  bst_pkg::bst_state_t state
);

	bst_pkg::bst_state_t next_state;

	always_comb
	begin
		next_state = state;
		if (por)
			next_state = bst_pkg::ST_TLR; // see RULE2
		else
		begin
			unique case (state) // see RULE1 see RULE23
				bst_pkg::ST_TLR:
					next_state = tms ? bst_pkg::ST_TLR : bst_pkg::ST_RTI;
				bst_pkg::ST_RTI:
					next_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
				bst_pkg::ST_SEL_DR:
					next_state = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
				bst_pkg::ST_CAP_DR:
					next_state = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
				bst_pkg::ST_SH_DR:
					next_state = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
				bst_pkg::ST_EX1_DR:
					next_state = tms ? bst_pkg::ST_UP_DR : bst_pkg::ST_PA_DR;
				bst_pkg::ST_PA_DR:
					next_state = tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
				bst_pkg::ST_EX2_DR:
					next_state = tms ? bst_pkg::ST_UP_DR : bst_pkg::ST_SH_DR;
				bst_pkg::ST_UP_DR:
					next_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
				// Five high TMS edges reach reset from any state
				bst_pkg::ST_SEL_IR:
					next_state = tms ? bst_pkg::ST_TLR : bst_pkg::ST_CAP_IR; // see RULE21
				bst_pkg::ST_CAP_IR:
					next_state = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
				bst_pkg::ST_SH_IR:
					next_state = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
				bst_pkg::ST_EX1_IR:
					next_state = tms ? bst_pkg::ST_UP_IR : bst_pkg::ST_PA_IR;
				bst_pkg::ST_PA_IR:
					next_state = tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
				bst_pkg::ST_EX2_IR:
					next_state = tms ? bst_pkg::ST_UP_IR : bst_pkg::ST_SH_IR;
				bst_pkg::ST_UP_IR:
					next_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
				default:
					next_state = bst_pkg::ST_TLR;
			endcase
		end
	end

	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			state <= bst_pkg::ST_TLR;
		else
			state <= next_state;
	end

endmodule

`default_nettype wire

// ### verif/bst_tap_chk.sv
`timescale 1ns/10ps
`default_nettype none

module bst_tap_chk (
	input wire logic       sys_clk,
	input wire logic       srst,
	input wire logic       tck,
	input wire logic       trst_n,
	input wire logic       tms,
	input wire logic       tdi,
	input wire logic       tdo,
	input wire logic       tdo_oe,
	input wire logic [1:0] core_out,
	input wire logic [3:0] core_in,
	input wire logic [7:0] core_bidir_in,
	input wire logic [3:0] pad_in,
	input wire logic [1:0] pad_out,
	input wire logic [7:0] pad_bidir_in,
	input wire logic       scan_en,
	input wire logic       pins_held
);
	sequence s_five;
		tms [*5];
	endsequence
	// From test-logic-reset into a shift state
	sequence s_to_dr;
		s_five ##1 !tms ##1 tms ##1 !tms [*2];
	endsequence
	sequence s_to_ir;
		s_five ##1 !tms ##1 tms [*2] ##1 !tms [*2];
	endsequence
	property p_core_in;
		@(posedge sys_clk) disable iff (srst) core_in == pad_in;
	endproperty
	property p_bidir_in;
		@(posedge sys_clk) disable iff (srst) core_bidir_in == pad_bidir_in;
	endproperty
	// Five samples, as pins_held trails the tck-side mode
	property p_follow;
		@(posedge sys_clk) disable iff (srst)
			!pins_held [*5] |-> $past(pad_out, 4) == $past(core_out, 4);
	endproperty
	property p_srst_rel;
		@(posedge sys_clk) disable iff (srst)
			$fell(srst) |-> !scan_en && !pins_held;
	endproperty
	property p_tms_reset;
		@(posedge tck) disable iff (!trst_n)
			s_five |=> !tdo_oe && pad_out == core_out;
	endproperty
	property p_ir_cap;
		@(posedge tck) disable iff (!trst_n) s_to_ir |=> tdo_oe && tdo;
	endproperty
	property p_dr_cap;
		@(posedge tck) disable iff (!trst_n) s_to_dr |=> tdo_oe && !tdo;
	endproperty
	property p_bypass;
		@(posedge tck) disable iff (!trst_n)
			s_to_dr ##1 !tms |=> tdo == $past(tdi);
	endproperty
	a_core_in: assert property (p_core_in)
		else $error("core_in mismatch");
	a_bidir_in: assert property (p_bidir_in)
		else $error("core_bidir_in mismatch");
	a_follow: assert property (p_follow)
		else $error("pad_out not following core");
	a_srst_rel: assert property (p_srst_rel)
		else $error("modes set after reset");
	a_tms_reset: assert property (p_tms_reset)
		else $error("no reset after tms high");
	a_ir_cap: assert property (p_ir_cap)
		else $error("instruction capture bit");
	a_dr_cap: assert property (p_dr_cap)
		else $error("data capture bit");
	a_bypass: assert property (p_bypass)
		else $error("bypass path");
endmodule

bind bst_tap bst_tap_chk i_bst_tap_chk (.*);

`default_nettype wire

// ### verif/bst_tap_tb.sv
`timescale 1ns/10ps
`default_nettype none

module bst_tap_tb;
	logic                sys_clk = 1'b0;
	logic                srst = 1'b1;
	logic                tck, trst_n, tms, tdi, tdo, tdo_oe;
	logic                core_bidir_oe = 1'b0;
	logic                pad_bidir_oe, scan_en, pins_held;
	logic [1:0]          core_out = 2'h0;
	logic [1:0]          pad_out;
	logic [3:0]          pad_in = 4'h0;
	logic [3:0]          core_in;
	logic [7:0]          core_bidir_out = 8'h00;
	logic [7:0]          core_bidir_in, pad_bidir_out, pad_bidir_in;
	logic [10:0]         drive;
	bst_pkg::bst_cells_t pre = 15'h4E75;
	bst_pkg::bst_cells_t upd = 15'h0C1B;
	int                  bad_count = 0;
	int                  num_checks = 0;

	always #50 sys_clk = ~sys_clk;
	// Board drives its own pattern while the pins float
	assign pad_bidir_in = pad_bidir_oe ? pad_bidir_out : 8'hC3;
	assign drive = {pad_bidir_oe, pad_bidir_out, pad_out};

	bst_tap i_bst_tap (.*);
	bst_tester i_bst_tester (.*);

	task automatic check(input string what, input logic [14:0] exp,
		input logic [14:0] got);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic pins(input logic [1:0] o, input logic [3:0] i);
		@(posedge sys_clk);
		#1;
		core_out = o;
		core_bidir_out = 8'h5A;
		core_bidir_oe = 1'b1;
		pad_in = i;
	endtask

	task automatic load(input logic [4:0] op);
		logic [14:0] d;
		i_bst_tester.scan(1'b1, 5, {10'h000, op}, d);
		check("ir capture", 15'h000D, d);
		repeat (4) @(posedge sys_clk);
		#1;
	endtask

	task automatic t_bypass(input logic ld, input logic [4:0] op);
		logic [14:0] d;
		if (ld)
			load(op);
		i_bst_tester.scan(1'b0, 8, 15'h00A5, d);
		check("bypass", 15'h004A, d);
		check("pads", 15'(pad_out), 15'(core_out));
		check("scan_en", 15'(scan_en), 15'h0000);
	endtask

	task automatic t_extest;
		logic [14:0] d;
		pins(2'h2, 4'hA);
		load(bst_pkg::OP_SAMPLE);
		i_bst_tester.scan(1'b0, 15, pre, d);
		check("sample", {1'b1, 8'h5A, 2'h2, 4'hA}, d);
		pins(2'h2, 4'h6);
		load(bst_pkg::OP_EXTEST);
		check("preload", 15'(drive), 15'(pre[14:4]));
		check("held", 15'(pins_held), 15'h0001);
		i_bst_tester.scan(1'b0, 15, upd, d);
		check("capture", {pre[14:4], 4'h6}, d);
		check("update", 15'(drive), 15'(upd[14:4]));
	endtask

	task automatic t_clamp;
		logic [14:0] d;
		load(bst_pkg::OP_CLAMP);
		pins(2'h0, 4'h6);
		i_bst_tester.scan(1'b0, 4, 15'h0009, d);
		check("clamp path", 15'h0002, d);
		check("clamp pins", 15'(drive), 15'(upd[14:4]));
		i_bst_tester.tap_reset(1'b0);
		check("tms reset", 15'(pad_out), 15'(core_out));
	endtask

	task automatic t_trst;
		load(bst_pkg::INTERNAL_SCAN_ENABLE_OP);
		i_bst_tester.pulse_trst;
		repeat (4) @(posedge sys_clk);
		#1;
		check("trst scan_en", 15'(scan_en), 15'h0000);
	endtask

	initial
	begin
		#10;
		fork
			i_bst_tester.tap_reset(1'b1);
			repeat (12) @(posedge sys_clk);
		join
		#1;
		srst = 1'b0;
		i_bst_tester.tap_reset(1'b0);
		t_bypass(1'b0, 5'h1E);
		t_bypass(1'b1, 5'h1F);
		t_bypass(1'b1, 5'h03);
		t_extest;
		t_clamp;
		load(bst_pkg::INTERNAL_SCAN_ENABLE_OP);
		check("scan on", 15'(scan_en), 15'h0001);
		t_bypass(1'b1, bst_pkg::OP_BYPASS);
		t_trst;
		summarize;
	end

	initial
	begin
		#1ms;
		bad_count++;
		summarize;
	end
endmodule

`default_nettype wire

// ### verif/bst_tester.sv
`timescale 1ns/10ps
`default_nettype none

module bst_tester (
	output var  logic tck,
	output var  logic trst_n,
	output var  logic tms,
	output var  logic tdi,
	input  wire logic tdo
);
	initial
	begin
		tck = 1'b0;
		// Starts inactive so the first pulse gives a clean falling edge
		trst_n = 1'b1;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One test clock; tck rests low between frames
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#62.5;
		tck = 1'b1;
		q = tdo;
		#62.5;
		tck = 1'b0;
	endtask

	// Asynchronous test reset, tck left at rest
	task automatic pulse_trst;
		trst_n = 1'b0;
		#50;
		trst_n = 1'b1;
	endtask

	task automatic tap_reset(input logic hard);
		logic q;
		if (hard)
			pulse_trst;
		repeat (5) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask

	// Idle to idle, bits LSB first
	task automatic scan(input logic ir, input int n, input logic [14:0] din,
		output logic [14:0] dout);
		logic q;
		dout = 15'h0000;
		step(1'b1, 1'b0, q);
		if (ir)
			step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
endmodule

`default_nettype wire
